/* rtl/eeprom_host_map.svh */
// constants for the parallel eeprom write-protection host controller
`ifndef EEPROM_HOST_MAP_SVH
`define EEPROM_HOST_MAP_SVH
`define CLK_PERIOD_NS        10
`define STROBE_WIDTH_NS      100
`define STROBE_WIDTH_CYC     ((`STROBE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_RECOV_NS      50
`define STROBE_RECOV_CYC     ((`STROBE_RECOV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CMD_RECOV_NS         1000
`define CMD_RECOV_CYC        ((`CMD_RECOV_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_ACCESS_NS       300
`define READ_ACCESS_CYC      ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BYTE_LOAD_MAX_US     100
`define BYTE_LOAD_MAX_CYC    ((`BYTE_LOAD_MAX_US * 1000) / `CLK_PERIOD_NS)
`define PROG_CYCLE_MS        10
`define PROG_CYCLE_CYC       ((`PROG_CYCLE_MS * 1000000) / `CLK_PERIOD_NS)
`define PAGE_BYTES_MAX       64
`define LOCK_STEPS           3
`define UNLOCK_STEPS         6
`define COMPLEMENT_BIT       7
`define TOGGLE_BIT           6
`define TIMER_W              24
`endif

/* rtl/eeprom_host_pkg.sv */
// types shared by the eeprom host controller
package eeprom_host_pkg;
    typedef enum logic [1:0] {
        OP_PLAIN  = 2'h0,
        OP_LOCKED = 2'h1,
        OP_UNLOCK = 2'h2,
        OP_POLL   = 2'h3
    } op_e;
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_SETUP = 7'h02,
        ST_PULSE = 7'h04,
        ST_RECOV = 7'h08,
        ST_WAIT  = 7'h10,
        ST_READ  = 7'h20,
        ST_DONE  = 7'h40
    } state_e;
endpackage

/* rtl/bus_cycle.sv */
// one strobed write or read cycle on the parallel eeprom pins
`timescale 1ns/1ps
`include "eeprom_host_map.svh"
module bus_cycle
    import eeprom_host_pkg::*;
#(
    parameter int ADDR_W = 15
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    input  wire logic              start,
    input  wire logic              isRead,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wdata,
    input  wire logic [7:0]        pinDataIn,
    output logic                   done,
    output logic [7:0]             rdata,
    output logic [ADDR_W-1:0]      pinAddr,
    output logic [7:0]             pinDataOut,
    output logic                   pinDataOe,
    output logic                   chipSelectN,
    output logic                   writeStrobeN,
    output logic                   outputStrobeN
);
    initial begin
        if (ADDR_W < 7) $error("address must cover a page");
    end
    typedef enum logic [2:0] {
        BC_IDLE = 3'h1,
        BC_ACT  = 3'h2,
        BC_REC  = 3'h4
    } bc_e;
    bc_e        st;
    bc_e        next_st;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic       rd;
    logic       next_rd;
    logic [7:0] next_rdata;
    logic [ADDR_W-1:0] next_pinAddr;
    logic [7:0] next_pinDataOut;

    // strobe sequencing: output strobe stays high on writes, write strobe high on reads
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_rd = rd;
        next_rdata = rdata;
        next_pinAddr = pinAddr;
        next_pinDataOut = pinDataOut;
        done = 1'b0;
        unique case (st)
            BC_IDLE: if (start) begin
                next_st = BC_ACT;
                next_rd = isRead;
                next_pinAddr = addr;
                next_pinDataOut = wdata;
                next_cnt = 8'((isRead ? `READ_ACCESS_CYC : `STROBE_WIDTH_CYC) + 2);
            end
            BC_ACT: begin
                if (cnt == 8'h00) begin
                    next_st = BC_REC;
                    next_rdata = sync2;
                    next_cnt = 8'(`STROBE_RECOV_CYC);
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            BC_REC: begin
                if (cnt == 8'h00) begin
                    next_st = BC_IDLE;
                    done = 1'b1;
                end else begin
                    next_cnt = cnt - 8'h01;
                end
            end
            default: next_st = BC_IDLE;
        endcase
    end

    // state registers and two-stage sampling of the data pins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= BC_IDLE;
            cnt <= 8'h00;
            rd <= 1'b0;
            rdata <= 8'h00;
            pinAddr <= '0;
            pinDataOut <= 8'h00;
            sync1 <= 8'h00;
            sync2 <= 8'h00;
        end else if (clkEn) begin
            st <= next_st;
            cnt <= next_cnt;
            rd <= next_rd;
            rdata <= next_rdata;
            pinAddr <= next_pinAddr;
            pinDataOut <= next_pinDataOut;
            sync1 <= pinDataIn;
            sync2 <= sync1;
        end
    end

    // strobe width is held well above the glitch floor so the device accepts it
    assign chipSelectN = (st != BC_ACT);
    assign writeStrobeN = !(st == BC_ACT && !rd);
    assign outputStrobeN = !(st == BC_ACT && rd);
    assign pinDataOe = (st == BC_ACT && !rd);

    chk_write_oe_high: assert property (@(posedge core_clk) disable iff (sys_rst)
        !writeStrobeN |-> outputStrobeN && !chipSelectN) else $error("write strobe with output strobe low");
    chk_strobe_min_width: assert property (@(posedge core_clk) disable iff (sys_rst)
        $fell(writeStrobeN) && clkEn |-> !writeStrobeN [*8]) else $error("write strobe too short");
endmodule

/* rtl/eeprom_host.sv */
// host controller issuing plain, locked and unlock writes plus completion polling
// Contract
// - locked device needs prefix before each write
// - host sends three fixed command writes first
// - command always followed by a data write (host polls without one if no byte comes within half the byte-load window)
// - command writes go back to back
// - six writes unlock after one programming time
// - write when select and write strobe low
// - next byte within hundred microseconds
`timescale 1ns/1ps
`include "eeprom_host_map.svh"
module eeprom_host
    import eeprom_host_pkg::*;
#(
    parameter int ADDR_W = 15,
    parameter int PROG_TIMEOUT = `PROG_CYCLE_CYC,
    parameter logic [14:0] CMD_ADDR_A = 15'h0AAA,
    parameter logic [14:0] CMD_ADDR_B = 15'h0555,
    parameter logic [7:0]  CMD_DATA_A = 8'hAA,
    parameter logic [7:0]  CMD_DATA_B = 8'h55,
    parameter logic [7:0]  LOCK_DATA  = 8'hA0,
    parameter logic [7:0]  UNL_DATA_1 = 8'h80,
    parameter logic [7:0]  UNL_DATA_2 = 8'h20
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire logic              clkEn,
    input  wire logic              reqValid,
    output logic                   reqReady,
    input  wire op_e               reqOp,
    input  wire logic [ADDR_W-1:0] reqAddr,
    input  wire logic [6:0]        reqCount,
    input  wire logic              byteValid,
    output logic                   byteReady,
    input  wire logic [7:0]        byteData,
    output logic                   opDone,
    output logic                   opTimeout,
    output logic [7:0]             readData,
    output logic [ADDR_W-1:0]      pinAddr,
    output logic [7:0]             pinDataOut,
    output logic                   pinDataOe,
    input  wire logic [7:0]        pinDataIn,
    output logic                   chipSelectN,
    output logic                   writeStrobeN,
    output logic                   outputStrobeN
);
    initial begin
        if (ADDR_W != 15) $error("command addresses assume fifteen address bits");
        if (PROG_TIMEOUT < 1 || PROG_TIMEOUT >= (1 << `TIMER_W)) $error("timeout out of range");
    end

    // command step table: lock prefix, unlock sequence repeats the two command bytes before its last unlock byte
    function automatic logic [22:0] cmdStep(input logic unl, input logic [2:0] i);
        logic [22:0] r;
        r = {CMD_ADDR_A, CMD_DATA_A};
        unique case (i)
            3'h0: r = {CMD_ADDR_A, CMD_DATA_A};
            3'h1: r = {CMD_ADDR_B, CMD_DATA_B};
            3'h2: r = {CMD_ADDR_A, unl ? UNL_DATA_1 : LOCK_DATA};
            3'h3: r = {CMD_ADDR_A, CMD_DATA_A};
            3'h4: r = {CMD_ADDR_B, CMD_DATA_B};
            default: r = {CMD_ADDR_A, UNL_DATA_2};
        endcase
        return r;
    endfunction

    state_e            st;
    state_e            next_st;
    op_e               op;
    op_e               next_op;
    logic [2:0]        step;
    logic [2:0]        next_step;
    logic [6:0]        left;
    logic [6:0]        next_left;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [7:0]        last;
    logic [7:0]        next_last;
    logic [`TIMER_W-1:0] tmr;
    logic [`TIMER_W-1:0] next_tmr;
    logic              prevToggle;
    logic              next_prevToggle;
    logic              havePrev;
    logic              next_havePrev;
    logic              bcStart;
    logic              bcRead;
    logic [ADDR_W-1:0] bcAddr;
    logic [7:0]        bcData;
    logic              bcDone;
    logic [7:0]        bcRdata;
    logic              next_opDone;
    logic              next_opTimeout;
    logic [22:0]       cs;
    logic              polling;
    logic              next_polling;

    assign cs = cmdStep(op == OP_UNLOCK, step);
    assign reqReady = (st == ST_IDLE);
    assign byteReady = (st == ST_WAIT) && (op != OP_POLL) && (left != 7'h00);

    // sequencer: command prefix, page bytes, then poll until true data
    always_comb begin
        next_st = st;
        next_op = op;
        next_step = step;
        next_left = left;
        next_addr = addr;
        next_last = last;
        next_tmr = tmr;
        next_prevToggle = prevToggle;
        next_havePrev = havePrev;
        next_polling = polling;
        next_opDone = 1'b0;
        next_opTimeout = 1'b0;
        bcStart = 1'b0;
        bcRead = 1'b0;
        bcAddr = addr;
        bcData = last;
        unique case (st)
            ST_IDLE: if (reqValid) begin
                next_op = reqOp;
                next_addr = reqAddr;
                next_left = (reqCount == 7'h00 || reqCount > 7'(`PAGE_BYTES_MAX)) ? 7'(`PAGE_BYTES_MAX) : reqCount;
                next_step = 3'h0;
                next_havePrev = 1'b0;
                next_polling = 1'b0;
                // plain writes need no prefix on an unlocked part
                next_st = (reqOp == OP_LOCKED || reqOp == OP_UNLOCK) ? ST_SETUP : ST_WAIT;
                next_tmr = '0;
            end
            ST_SETUP: begin
                // command writes issued back to back
                bcStart = 1'b1;
                bcAddr = cs[22:8];
                bcData = cs[7:0];
                next_st = ST_PULSE;
            end
            ST_PULSE: if (bcDone) begin
                next_step = step + 3'h1;
                if (op == OP_LOCKED && step == 3'(`LOCK_STEPS - 1)) begin
                    // recovery, then the data write if a byte is offered before the wait limit
                    next_st = ST_RECOV;
                    next_tmr = `TIMER_W'(`CMD_RECOV_CYC);
                end else if (op == OP_UNLOCK && step == 3'(`UNLOCK_STEPS - 1)) begin
                    next_st = ST_READ; // wait programming time before standard mode
                    next_tmr = `TIMER_W'(PROG_TIMEOUT);
                end else begin
                    next_st = ST_SETUP;
                end
            end
            ST_RECOV: begin
                // poll timer runs down while reads are in flight; only the prefix recovery leaves at zero
                if (tmr != '0) next_tmr = tmr - `TIMER_W'(1);
                else if (!polling) next_st = ST_WAIT;
            end
            ST_WAIT: begin
                if (op == OP_POLL) begin
                    next_st = ST_READ;
                    next_tmr = `TIMER_W'(PROG_TIMEOUT);
                end else if (left != 7'h00 && byteValid) begin
                    // next byte load starts well inside the byte-load window
                    bcStart = 1'b1;
                    bcData = byteData;
                    next_last = byteData;
                    next_left = left - 7'h01;
                    next_st = ST_DONE;
                end else if (left != 7'h00 && tmr < `TIMER_W'(`BYTE_LOAD_MAX_CYC / 2) && !havePrev) begin
                    next_tmr = tmr + `TIMER_W'(1);
                end else if (havePrev || left == 7'h00 || tmr != '0) begin
                    // page closes when bytes stop; device programs, and locks if the page was prefixed
                    next_st = ST_READ;
                    next_havePrev = 1'b0;
                    next_tmr = `TIMER_W'(PROG_TIMEOUT);
                end
            end
            ST_DONE: if (bcDone) begin
                next_addr = addr + ADDR_W'(1);
                next_st = ST_WAIT;
                next_tmr = '0;
                next_havePrev = (left == 7'h00);
            end
            ST_READ: begin
                // polling reads of last byte written; poll and unlock requests read the request address
                bcStart = 1'b1;
                bcRead = 1'b1;
                next_polling = 1'b1;
                bcAddr = addr - ADDR_W'(op == OP_POLL || op == OP_UNLOCK ? 0 : 1);
                next_st = ST_RECOV;
                if (tmr == '0) begin
                    next_opDone = 1'b1;
                    next_opTimeout = 1'b1;
                    next_st = ST_IDLE;
                    bcStart = 1'b0;
                end
            end
            default: next_st = ST_IDLE;
        endcase
        // poll read result: done when toggling stops and, for page writes, bit seven is true
        if (st == ST_RECOV && polling && bcDone) begin
            if (havePrev && bcRdata[`TOGGLE_BIT] == prevToggle &&
                (op == OP_UNLOCK || bcRdata[`COMPLEMENT_BIT] == last[`COMPLEMENT_BIT] || op == OP_POLL)) begin
                next_opDone = 1'b1;
                next_st = ST_IDLE;
            end else begin
                next_st = ST_READ;
            end
            next_prevToggle = bcRdata[`TOGGLE_BIT];
            next_havePrev = 1'b1;
        end
    end

    // control registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            st <= ST_IDLE;
            op <= OP_PLAIN;
            step <= 3'h0;
            left <= 7'h00;
            addr <= '0;
            last <= 8'h00;
            tmr <= '0;
            prevToggle <= 1'b0;
            havePrev <= 1'b0;
            polling <= 1'b0;
            opDone <= 1'b0;
            opTimeout <= 1'b0;
        end else if (clkEn) begin
            st <= next_st;
            op <= next_op;
            step <= next_step;
            left <= next_left;
            addr <= next_addr;
            last <= next_last;
            tmr <= next_tmr;
            prevToggle <= next_prevToggle;
            havePrev <= next_havePrev;
            polling <= next_polling;
            opDone <= next_opDone;
            opTimeout <= next_opTimeout;
        end
    end
    assign readData = bcRdata;

    bus_cycle #(.ADDR_W(ADDR_W)) cycle (
        .core_clk      (core_clk),
        .sys_rst       (sys_rst),
        .clkEn         (clkEn),
        .start         (bcStart && clkEn),
        .isRead        (bcRead),
        .addr          (bcAddr),
        .wdata         (bcData),
        .pinDataIn     (pinDataIn),
        .done          (bcDone),
        .rdata         (bcRdata),
        .pinAddr       (pinAddr),
        .pinDataOut    (pinDataOut),
        .pinDataOe     (pinDataOe),
        .chipSelectN   (chipSelectN),
        .writeStrobeN  (writeStrobeN),
        .outputStrobeN (outputStrobeN)
    );

    chk_page_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
        left <= 7'(`PAGE_BYTES_MAX)) else $error("page larger than limit");
    chk_lock_prefix: assert property (@(posedge core_clk) disable iff (sys_rst)
        st == ST_WAIT && op == OP_LOCKED |-> step == 3'(`LOCK_STEPS)) else $error("data before full prefix");
    chk_byte_gap: assert property (@(posedge core_clk) disable iff (sys_rst)
        st == ST_WAIT && op != OP_POLL |-> tmr <= `TIMER_W'(`BYTE_LOAD_MAX_CYC)) else $error("byte gap too long");
    chk_unlock_count: assert property (@(posedge core_clk) disable iff (sys_rst)
        op == OP_UNLOCK |-> step <= 3'(`UNLOCK_STEPS)) else $error("too many unlock writes");
    chk_idle_quiet: assert property (@(posedge core_clk) disable iff (sys_rst)
        st == ST_IDLE |-> writeStrobeN) else $error("write while idle");
    chk_done_pulse: assert property (@(posedge core_clk) disable iff (sys_rst)
        opDone |=> !opDone) else $error("done longer than a cycle");
endmodule

/* dv/eeprom_model.sv */
// behavioural parallel eeprom with software write lock, page buffer and status bits
`timescale 1ns/1ps
module eeprom_model #(
    parameter int          ADDR_W     = 15,
    parameter int          PROG_NS    = 4000,
    parameter int          LOAD_NS    = 1000,
    parameter int          GLITCH_NS  = 20,
    parameter logic [14:0] CMD_ADDR_A = 15'h0AAA,
    parameter logic [14:0] CMD_ADDR_B = 15'h0555,
    parameter logic [7:0]  CMD_DATA_A = 8'hAA,
    parameter logic [7:0]  CMD_DATA_B = 8'h55,
    parameter logic [7:0]  LOCK_DATA  = 8'hA0,
    parameter logic [7:0]  UNL_DATA_1 = 8'h80,
    parameter logic [7:0]  UNL_DATA_2 = 8'h20
) (
    input  wire logic [ADDR_W-1:0] pinAddr,
    input  wire logic [7:0]        pinDataOut,
    input  wire logic              pinDataOe,
    input  wire logic              chipSelectN,
    input  wire logic              writeStrobeN,
    input  wire logic              outputStrobeN,
    input  wire logic              supplyOk,
    output logic [7:0]             pinDataIn
);
    logic [7:0]        mem [2**ADDR_W];
    logic [7:0]        pageData [64];
    logic [ADDR_W-1:0] pageAddr [64];
    logic [14:0]       seqAddr [6];
    logic [7:0]        seqData [6];
    int                pageCnt = 0;
    int                step = 0;
    logic              locked = 1'b0; // delivered unlocked
    logic              windowOpen = 1'b0;
    logic              lockOnCommit = 1'b0;
    logic              unlockPending = 1'b0;
    logic              busy = 1'b0;
    logic              toggle = 1'b0;
    logic [ADDR_W-1:0] lastAddr = '0;
    logic [ADDR_W-1:0] wrAddr = '0;
    logic [7:0]        lastData = 8'h00;
    logic [7:0]        floatVal = 8'h5A;
    logic [7:0]        baseVal;
    logic [7:0]        driveVal;
    realtime           tFall = 0;
    realtime           tLoad = 0;
    realtime           tDone = 0;
    wire               wrActive = !chipSelectN && !writeStrobeN && outputStrobeN;
    wire               rdActive = !chipSelectN && !outputStrobeN && writeStrobeN;

    // erased array and the command table
    initial begin
        foreach (mem[i]) mem[i] = 8'hFF;
        seqAddr = '{CMD_ADDR_A, CMD_ADDR_B, CMD_ADDR_A, CMD_ADDR_A, CMD_ADDR_B, CMD_ADDR_A};
        seqData = '{CMD_DATA_A, CMD_DATA_B, UNL_DATA_1, CMD_DATA_A, CMD_DATA_B, UNL_DATA_2};
    end

    task automatic start_prog();
        busy = 1'b1;
        tDone = $realtime + PROG_NS;
    endtask

    // command recognition and page loading for one accepted byte
    task automatic accept(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        if (step == 2 && a == CMD_ADDR_A && d == LOCK_DATA) begin
            windowOpen = 1'b1; // three writes open the page window
            step = 0;
        end else if (a == seqAddr[step] && d == seqData[step]) begin
            step++;
            if (step == 6) begin
                unlockPending = 1'b1; // six writes clear the lock
                step = 0;
                start_prog();
            end
        end else begin
            step = 0; // a stray write breaks any command
            if ((!locked || windowOpen) && pageCnt < 64) begin // prefix needed while locked
                pageAddr[pageCnt] = a;
                pageData[pageCnt] = d;
                pageCnt++;
                lastAddr = a;
                lastData = d;
                lockOnCommit = lockOnCommit || windowOpen; // first prefixed write sets the lock
                tLoad = $realtime;
            end
        end
    endtask

    // address at the opening edge, data at the closing edge
    always @(posedge wrActive) begin
        wrAddr = pinAddr;
        tFall = $realtime;
    end
    always @(negedge wrActive) begin
        if ($realtime - tFall >= GLITCH_NS && supplyOk && !busy)
            accept(wrAddr, pinDataOut);
    end

    // load window expiry, end of programming, supply loss and floating bus pattern
    always #10 begin
        floatVal = ~floatVal;
        if (!busy && pageCnt > 0 && $realtime - tLoad > LOAD_NS)
            start_prog();
        if (busy && $realtime >= tDone) begin
            for (int k = 0; k < pageCnt; k++)
                mem[pageAddr[k]] = pageData[k];
            locked = (locked || lockOnCommit) && !unlockPending; // relock after the page
            pageCnt = 0;
            windowOpen = 1'b0;
            lockOnCommit = 1'b0;
            unlockPending = 1'b0;
            busy = 1'b0;
        end
        if (!supplyOk && !busy) begin // lock survives supply loss
            pageCnt = 0;
            step = 0;
            windowOpen = 1'b0;
            lockOnCommit = 1'b0;
        end
    end

    // a read during page load starts programming, each read while busy flips the toggle bit
    always @(posedge rdActive) begin
        if (!busy && pageCnt > 0)
            start_prog();
        if (busy)
            toggle = !toggle;
    end

    // read data with status bits while programming, bus resolution otherwise
    assign baseVal = (busy && pinAddr == lastAddr) ? lastData : mem[pinAddr];
    assign driveVal = busy ? {baseVal[7] ^ (pinAddr == lastAddr), toggle, baseVal[5:0]} : baseVal;
    assign pinDataIn = pinDataOe ? pinDataOut : (rdActive ? driveVal : floatVal);
endmodule

/* dv/eeprom_write_protection_bench.sv */
// self-checking bench for the eeprom host controller against the behavioural device
`timescale 1ns/1ps
module eeprom_write_protection_bench;
    import eeprom_host_pkg::*;
    typedef struct packed {logic timeout; logic chk; logic [7:0] data;} result_s;
    logic        core_clk  = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        clkEn     = 1'b1;
    logic        reqValid  = 1'b0;
    logic        byteValid = 1'b0;
    logic        supplyOk  = 1'b1;
    op_e         reqOp     = OP_PLAIN;
    logic [14:0] reqAddr   = 15'h0000;
    logic [6:0]  reqCount  = 7'h01;
    logic [7:0]  byteData  = 8'h00;
    logic        reqReady, byteReady, opDone, opTimeout, pinDataOe, chipSelectN, writeStrobeN, outputStrobeN;
    logic [7:0]  readData, pinDataOut, pinDataIn;
    logic [14:0] pinAddr;
    logic [7:0]  pageBuf [64];
    result_s     expQ [$];
    result_s     cur;
    int          errors    = 0;
    int          tests_run = 0;
    int          doneCnt   = 0;
    logic [31:0] rngState  = 32'hF5FA;

    always #5 core_clk = ~core_clk;

    eeprom_host #(.PROG_TIMEOUT(2000)) u_eeprom_host (
        .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .reqValid(reqValid), .reqReady(reqReady),
        .reqOp(reqOp), .reqAddr(reqAddr), .reqCount(reqCount), .byteValid(byteValid), .byteReady(byteReady),
        .byteData(byteData), .opDone(opDone), .opTimeout(opTimeout), .readData(readData), .pinAddr(pinAddr),
        .pinDataOut(pinDataOut), .pinDataOe(pinDataOe), .pinDataIn(pinDataIn), .chipSelectN(chipSelectN),
        .writeStrobeN(writeStrobeN), .outputStrobeN(outputStrobeN));

    eeprom_model u_eeprom_model (
        .pinAddr(pinAddr), .pinDataOut(pinDataOut), .pinDataOe(pinDataOe), .chipSelectN(chipSelectN),
        .writeStrobeN(writeStrobeN), .outputStrobeN(outputStrobeN), .supplyOk(supplyOk), .pinDataIn(pinDataIn));

    function automatic logic [31:0] next_rand();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction

    task automatic check_flag(input string name, input logic e, input logic s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %b seen %b", name, e, s);
        end
    endtask

    task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] s);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic fill_page();
        foreach (pageBuf[k]) pageBuf[k] = 8'(next_rand());
    endtask

    // one request, its bytes with random gaps, then a bounded wait for completion
    task automatic do_op(input op_e op, input logic [14:0] a, input int n, input logic chk, input logic [7:0] e,
                         input logic tmo);
        int start;
        int w;
        start = doneCnt;
        expQ.push_back('{tmo, chk, e});
        @(posedge core_clk);
        reqValid <= 1'b1;
        reqOp <= op;
        reqAddr <= a;
        reqCount <= 7'(n);
        @(posedge core_clk);
        while (reqReady !== 1'b1) @(posedge core_clk);
        reqValid <= 1'b0;
        for (int k = 0; k < n; k++) begin
            w = next_rand() % 3;
            if (w > 0) begin
                byteValid <= 1'b0;
                repeat (w) @(posedge core_clk);
            end
            byteValid <= 1'b1;
            byteData <= pageBuf[k];
            @(posedge core_clk);
            while (byteReady !== 1'b1) @(posedge core_clk);
        end
        byteValid <= 1'b0;
        w = 0;
        while (doneCnt == start && w < 6000) begin
            @(posedge core_clk);
            w++;
        end
        if (doneCnt == start) check_flag("opDone", 1'b1, 1'b0);
    endtask

    // completion watcher pairs each opDone with the oldest note
    always @(posedge core_clk) begin
        if (!sys_rst && opDone === 1'b1) begin
            doneCnt++;
            if (expQ.size() == 0) begin
                check_flag("spare opDone", 1'b0, 1'b1);
            end else begin
                cur = expQ.pop_front();
                check_flag("opTimeout", cur.timeout, opTimeout);
                if (cur.chk) check_byte("readData", cur.data, readData);
            end
        end
    end

    // hang guard
    initial begin
        repeat (80000) @(posedge core_clk);
        errors++;
        $display("ERROR watchdog expected finish seen hang");
        stop_test();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        check_flag("locked", 1'b0, u_eeprom_model.locked);
        fill_page();
        do_op(OP_PLAIN, 15'h0100, 1, 1'b0, 8'h00, 1'b0);
        check_byte("mem", pageBuf[0], u_eeprom_model.mem[15'h0100]);
        do_op(OP_POLL, 15'h0100, 0, 1'b1, pageBuf[0], 1'b0);
        fill_page();
        do_op(OP_LOCKED, 15'h0200, 64, 1'b0, 8'h00, 1'b0);
        for (int k = 0; k < 64; k++)
            check_byte("page", pageBuf[k], u_eeprom_model.mem[15'h0200 + k]);
        check_flag("locked", 1'b1, u_eeprom_model.locked);
        fill_page();
        // a refused byte stays erased, so the data poll only settles when bit seven was set
        do_op(OP_PLAIN, 15'h0300, 1, 1'b0, 8'h00, !pageBuf[0][7]);
        check_byte("mem", 8'hFF, u_eeprom_model.mem[15'h0300]);
        supplyOk <= 1'b0;
        do_op(OP_LOCKED, 15'h0310, 2, 1'b0, 8'h00, !pageBuf[1][7]);
        check_byte("mem", 8'hFF, u_eeprom_model.mem[15'h0310]);
        supplyOk <= 1'b1;
        repeat (5) @(posedge core_clk);
        check_flag("locked", 1'b1, u_eeprom_model.locked);
        fill_page();
        do_op(OP_LOCKED, 15'h0301, 1, 1'b0, 8'h00, 1'b0);
        check_byte("mem", pageBuf[0], u_eeprom_model.mem[15'h0301]);
        do_op(OP_UNLOCK, 15'h0000, 0, 1'b0, 8'h00, 1'b0);
        check_flag("locked", 1'b0, u_eeprom_model.locked);
        fill_page();
        do_op(OP_PLAIN, 15'h0400, 3, 1'b0, 8'h00, 1'b0);
        for (int k = 0; k < 3; k++)
            check_byte("page", pageBuf[k], u_eeprom_model.mem[15'h0400 + k]);
        stop_test();
    end
endmodule
